// [rtl/isbc_pkg.sv]
package isbc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CPU_BASE  = 8'hcd;
    localparam logic [7:0] ADDR_CPU_CUR   = 8'hce;
    localparam logic [7:0] ADDR_BUF_PORT  = 8'hcf;
    localparam logic [7:0] ADDR_CONFIG    = 8'hd6;
    localparam logic [7:0] ADDR_SCR       = 8'hd7;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'he8;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'he9;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CFG_ENABLE    = 0;
    localparam int CFG_RATE_LO   = 2;
    localparam int CFG_RATE_HI   = 3;
    localparam int CFG_STOP_IRQ_ENABLE   = 4;
    localparam int CFG_FAULT_IE  = 5;
    localparam int CFG_PIN_SEL   = 6;
    localparam logic [7:0] CFG_WR_MASK = 8'h7d;
    localparam logic [7:0] CFG_RESET   = 8'h00;

    localparam int SCR_BYTE_DONE = 0;
    localparam int SCR_LRB       = 1;
    localparam int SCR_TRANSMIT  = 2;
    localparam int SCR_ADDRESS   = 3;
    localparam int SCR_ACK       = 4;
    localparam int SCR_STOP      = 5;
    localparam int SCR_FAULT     = 7;
    localparam logic [7:0] SCR_RESET   = 8'h00;

    localparam int IRQ_W         = 3;
    localparam int IRQ_BYTE_DONE = 0;
    localparam int IRQ_ADDRESS   = 1;
    localparam int IRQ_STOP      = 2;
    localparam logic [2:0] IRQ_RESET   = 3'h0;

    // ------------------------------------------------------------------
    // Rate codes and data setup before releasing a stretched clock
    // ------------------------------------------------------------------
    localparam logic [1:0] RATE_100K = 2'h0;
    localparam logic [1:0] RATE_400K = 2'h1;
    localparam logic [1:0] RATE_50K  = 2'h2;

    localparam int CLK_PERIOD_NS  = 5;
    localparam int SETUP_100K_NS  = 2500;
    localparam int SETUP_400K_NS  = 625;
    localparam int SETUP_50K_NS   = 5000;
    localparam int CNT_W          = 10;
    localparam logic [CNT_W-1:0] SETUP_100K_CYC = CNT_W'(
        (SETUP_100K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SETUP_400K_CYC = CNT_W'(
        (SETUP_400K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SETUP_50K_CYC  = CNT_W'(
        (SETUP_50K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } isbc_bus_req_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } isbc_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_RX     = 3'h1,
        ST_HOLD   = 3'h2,
        ST_SETUP  = 3'h3,
        ST_ACK    = 3'h4,
        ST_TX     = 3'h5,
        ST_TX_ACK = 3'h6
    } isbc_state_t;

endpackage : isbc_pkg

// [rtl/isbc_slave_ctrl.sv]
// Summary of operation
// - Buffer port read returns byte at pointer
// - Buffer port write stores byte at pointer
// - Never-written buffer locations read undefined
// - Config bit 6 selects bus pin pair
// - Config bit 4 enables Stop interrupt
// - Rate field bits 3:2 selects setup time before a stretched clock is released
// - Status register held reset while disabled
// - Bus fault bit and enable have no effect
// - Stop sets status bit 5, firmware clears
// - Ack bit cleared on byte complete
// - Address byte sets status bit 3
// - Transmit bit cleared by Start
// - Bit 1 captures ninth-bit acknowledge
// - Byte complete set after byte, Start clears
// - Each buffer port access advances pointer
// - Pointer wraps to zero past last location
//
// Design decision made here: the plain strobed port.
module isbc_slave_ctrl #(
    parameter int BUF_DEPTH = 32,
    parameter int PTR_W     = 5
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  reset_n_in,
    input  wire isbc_pkg::isbc_bus_req_t bus_req_in,
    output logic [7:0]                 rd_data_out,
    output logic                       irq_out,
    input  wire isbc_pkg::isbc_pins_t [1:0] pin_pair_in,
    output logic [1:0]                 scl_out,
    output logic [1:0]                 scl_oe_out,
    output logic [1:0]                 sda_out,
    output logic [1:0]                 sda_oe_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Pointer wrap relies on the depth filling the pointer width exactly
    if (BUF_DEPTH != (1 << PTR_W) || PTR_W > 8)
    begin : g_bad_depth
        $error("BUF_DEPTH must equal 2**PTR_W, PTR_W at most 8");
    end

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    logic [7:0]       cfg_reg;
    logic [7:0]       scr_reg;
    logic [PTR_W-1:0] cpu_base_reg;
    logic [PTR_W-1:0] cpu_current_pointer;
    logic [2:0]       irq_stat_reg;
    logic [2:0]       irq_mask_reg;
    logic [7:0]       buf_mem [BUF_DEPTH];

    wire [7:0] addr   = bus_req_in.addr;
    wire [7:0] wdata  = bus_req_in.wdata;
    wire wr_cfg       = bus_req_in.wr && addr == isbc_pkg::ADDR_CONFIG;
    wire wr_scr       = bus_req_in.wr && addr == isbc_pkg::ADDR_SCR;
    wire wr_base      = bus_req_in.wr && addr == isbc_pkg::ADDR_CPU_BASE;
    wire wr_buf       = bus_req_in.wr && addr == isbc_pkg::ADDR_BUF_PORT;
    wire rd_buf       = bus_req_in.rd && addr == isbc_pkg::ADDR_BUF_PORT;
    wire wr_istat     = bus_req_in.wr && addr == isbc_pkg::ADDR_IRQ_STAT;
    wire wr_imask     = bus_req_in.wr && addr == isbc_pkg::ADDR_IRQ_MASK;

    // Config fields; fault enable is stored but steers nothing
    wire       cfg_en   = cfg_reg[isbc_pkg::CFG_ENABLE];
    wire       stop_irq_enable  = cfg_reg[isbc_pkg::CFG_STOP_IRQ_ENABLE];
    wire       pin_sel  = cfg_reg[isbc_pkg::CFG_PIN_SEL];
    wire [1:0] rate     = cfg_reg[isbc_pkg::CFG_RATE_HI:isbc_pkg::CFG_RATE_LO];

    // Buffer byte at the pointer; unwritten entries are never reset
    wire [7:0] buf_at_cp = buf_mem[cpu_current_pointer];

    // ------------------------------------------------------------------
    // Pin synchronisers and bus condition detect
    // ------------------------------------------------------------------
    isbc_pkg::isbc_pins_t [1:0] sync1_reg;
    isbc_pkg::isbc_pins_t [1:0] sync2_reg;
    logic                       scl_d_reg;
    logic                       sda_d_reg;

    // Pin pair chosen by the select bit
    wire scl_s     = sync2_reg[pin_sel].scl;
    wire sda_s     = sync2_reg[pin_sel].sda;

    // Both pairs are synchronised so a pair switch sees settled levels
    always_ff @(posedge core_clk_in)
    begin
        sync1_reg <= pin_pair_in;
        sync2_reg <= sync1_reg;
        scl_d_reg <= scl_s;
        sda_d_reg <= sda_s;
    end

    wire scl_rise  = scl_s & ~scl_d_reg;
    wire scl_fall  = ~scl_s & scl_d_reg;
    wire start_det = cfg_en & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_det  = cfg_en & scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ------------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------------
    isbc_pkg::isbc_state_t              state_reg;
    logic [3:0]                         bit_cnt_reg;
    logic [7:0]                         shift_reg;
    logic                               first_byte_reg;
    logic                               was_tx_reg;
    logic [PTR_W-1:0]                   bus_ptr_reg;
    logic [isbc_pkg::CNT_W-1:0]         setup_cnt_reg;

    wire ack_bit  = scr_reg[isbc_pkg::SCR_ACK];
    wire tx_bit   = scr_reg[isbc_pkg::SCR_TRANSMIT];
    wire lrb_bit  = scr_reg[isbc_pkg::SCR_LRB];

    // Events that feed the status register
    wire rx_done  = state_reg == isbc_pkg::ST_RX && scl_fall
                    && bit_cnt_reg == 4'h8;
    wire addr_set = rx_done & first_byte_reg;
    wire rx_store = rx_done & ~first_byte_reg;
    wire tx_done  = state_reg == isbc_pkg::ST_TX_ACK && scl_fall;
    wire lrb_cap  = state_reg == isbc_pkg::ST_TX_ACK && scl_rise;
    wire bc_set   = rx_done | tx_done;
    wire nack_end = state_reg == isbc_pkg::ST_HOLD && wr_scr
                    && was_tx_reg && lrb_bit;
    wire go_setup = state_reg == isbc_pkg::ST_HOLD && wr_scr && !nack_end;
    wire bus_ptr_max = bus_ptr_reg == {PTR_W{1'b1}};
    wire [PTR_W-1:0] bus_ptr_inc = bus_ptr_max ? bus_ptr_reg
                                   : PTR_W'(bus_ptr_reg + 1'b1);
    wire [7:0] bus_byte = buf_mem[bus_ptr_reg];

    // Setup time before a stretched clock is let go
    wire [isbc_pkg::CNT_W-1:0] setup_load =
        (rate == isbc_pkg::RATE_400K) ? isbc_pkg::SETUP_400K_CYC :
        (rate == isbc_pkg::RATE_50K)  ? isbc_pkg::SETUP_50K_CYC  :
                                        isbc_pkg::SETUP_100K_CYC;

    // Pin drive, low-only; the clock is stretched while firmware decides
    wire scl_drive = state_reg == isbc_pkg::ST_HOLD
                     || state_reg == isbc_pkg::ST_SETUP;
    wire ack_phase = state_reg == isbc_pkg::ST_ACK
                     || (state_reg == isbc_pkg::ST_SETUP && !was_tx_reg);
    wire tx_phase  = state_reg == isbc_pkg::ST_TX
                     || (state_reg == isbc_pkg::ST_SETUP && was_tx_reg);
    wire sda_drive = (ack_phase & ack_bit) | (tx_phase & ~shift_reg[7]);

    // Stop and Start override whatever byte is in flight
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in || !cfg_en || stop_det)
        begin
            state_reg      <= isbc_pkg::ST_IDLE;
            bit_cnt_reg    <= 4'h0;
            first_byte_reg <= 1'b0;
            was_tx_reg     <= 1'b0;
            bus_ptr_reg    <= '0;
            setup_cnt_reg  <= '0;
        end
        else if (start_det)
        begin
            state_reg      <= isbc_pkg::ST_RX;
            bit_cnt_reg    <= 4'h0;
            first_byte_reg <= 1'b1;
            bus_ptr_reg    <= '0;
        end
        else
        begin
            unique case (state_reg)
                isbc_pkg::ST_IDLE: ;
                isbc_pkg::ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_reg   <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    if (rx_done)
                    begin
                        state_reg  <= isbc_pkg::ST_HOLD;
                        was_tx_reg <= 1'b0;
                    end
                    if (rx_store)
                        bus_ptr_reg <= bus_ptr_inc;
                end
                isbc_pkg::ST_HOLD:
                begin
                    if (nack_end)
                        state_reg <= isbc_pkg::ST_IDLE;
                    else if (go_setup)
                    begin
                        state_reg     <= isbc_pkg::ST_SETUP;
                        setup_cnt_reg <= setup_load;
                        if (was_tx_reg)
                            shift_reg <= bus_byte;
                    end
                end
                isbc_pkg::ST_SETUP:
                begin
                    setup_cnt_reg <= setup_cnt_reg - 1'b1;
                    if (setup_cnt_reg == '0)
                    begin
                        state_reg   <= was_tx_reg ? isbc_pkg::ST_TX
                                                  : isbc_pkg::ST_ACK;
                        bit_cnt_reg <= 4'h0;
                    end
                end
                isbc_pkg::ST_ACK:
                begin
                    // Not acknowledged: stay off the bus until Start/Stop
                    if (scl_fall)
                    begin
                        bit_cnt_reg    <= 4'h0;
                        first_byte_reg <= 1'b0;
                        shift_reg      <= bus_byte;
                        state_reg      <= !ack_bit ? isbc_pkg::ST_IDLE :
                                          tx_bit   ? isbc_pkg::ST_TX
                                                   : isbc_pkg::ST_RX;
                    end
                end
                isbc_pkg::ST_TX:
                begin
                    if (scl_fall)
                    begin
                        shift_reg   <= {shift_reg[6:0], 1'b1};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == 4'h7)
                        begin
                            state_reg   <= isbc_pkg::ST_TX_ACK;
                            bus_ptr_reg <= bus_ptr_inc;
                        end
                    end
                end
                isbc_pkg::ST_TX_ACK:
                begin
                    if (tx_done)
                    begin
                        state_reg  <= isbc_pkg::ST_HOLD;
                        was_tx_reg <= 1'b1;
                    end
                end
                default: state_reg <= isbc_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Status and control register
    // ------------------------------------------------------------------
    // A written zero clears a status bit; hardware setting wins
    wire [7:0] clr = wr_scr ? ~wdata : 8'h00;
    wire stop_n = stop_det
                  | (scr_reg[isbc_pkg::SCR_STOP] & ~clr[isbc_pkg::SCR_STOP]);
    wire ack_n  = bc_set ? 1'b0
                  : wr_scr ? wdata[isbc_pkg::SCR_ACK] : ack_bit;
    wire addr_n = addr_set
                  | (scr_reg[isbc_pkg::SCR_ADDRESS]
                     & ~clr[isbc_pkg::SCR_ADDRESS]);
    wire tx_n   = start_det ? 1'b0
                  : wr_scr ? wdata[isbc_pkg::SCR_TRANSMIT] : tx_bit;
    wire lrb_n  = lrb_cap ? sda_s
                  : lrb_bit & ~clr[isbc_pkg::SCR_LRB] & ~start_det;
    wire bc_n   = bc_set
                  | (scr_reg[isbc_pkg::SCR_BYTE_DONE]
                     & ~clr[isbc_pkg::SCR_BYTE_DONE] & ~start_det);
    // Fault bit never sets on this part
    wire [7:0] scr_next = {1'b0, 1'b0, stop_n, ack_n,
                           addr_n, tx_n, lrb_n, bc_n};

    // Held at reset while the port is off
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in || !cfg_en)
            scr_reg <= isbc_pkg::SCR_RESET;
        else
            scr_reg <= scr_next;
    end

    // ------------------------------------------------------------------
    // Config, pointers and shared buffer
    // ------------------------------------------------------------------
    // Reserved bits drop on write; software keeps them zero
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
            cfg_reg <= isbc_pkg::CFG_RESET;
        else if (wr_cfg)
            cfg_reg <= wdata & isbc_pkg::CFG_WR_MASK;
    end

    // Pointer steps per access and wraps by width
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            cpu_base_reg        <= '0;
            cpu_current_pointer <= '0;
        end
        else if (wr_base)
        begin
            cpu_base_reg        <= wdata[PTR_W-1:0];
            cpu_current_pointer <= wdata[PTR_W-1:0];
        end
        else if (wr_buf || rd_buf)
            cpu_current_pointer <= PTR_W'(cpu_current_pointer + 1'b1);
    end

    // Bus side is written last, so it wins a same-entry collision
    always_ff @(posedge core_clk_in)
    begin
        if (wr_buf)
            buf_mem[cpu_current_pointer] <= wdata;
        if (rx_store)
            buf_mem[bus_ptr_reg] <= shift_reg;
    end

    // ------------------------------------------------------------------
    // Interrupt status, mask and read port
    // ------------------------------------------------------------------
    wire [2:0] irq_ev = {stop_det & stop_irq_enable, addr_set, bc_set};
    wire [2:0] irq_stat_next = irq_ev
                               | (irq_stat_reg & ~(wr_istat ? wdata[2:0]
                                                            : 3'h0));
    wire [2:0] irq_mask_next = wr_imask ? wdata[2:0] : irq_mask_reg;

    wire [7:0] rd_mux =
        (addr == isbc_pkg::ADDR_BUF_PORT) ? buf_at_cp
      : (addr == isbc_pkg::ADDR_CONFIG)   ? cfg_reg
      : (addr == isbc_pkg::ADDR_SCR)      ? scr_reg
      : (addr == isbc_pkg::ADDR_CPU_BASE) ? 8'(cpu_base_reg)
      : (addr == isbc_pkg::ADDR_CPU_CUR)  ? 8'(cpu_current_pointer)
      : (addr == isbc_pkg::ADDR_IRQ_STAT) ? {5'h00, irq_stat_reg}
      : (addr == isbc_pkg::ADDR_IRQ_MASK) ? {5'h00, irq_mask_reg}
      : 8'h00;

    // Interrupt follows next-state so it lines up with the status bits
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            irq_stat_reg <= isbc_pkg::IRQ_RESET;
            irq_mask_reg <= isbc_pkg::IRQ_RESET;
            irq_out      <= 1'b0;
            rd_data_out  <= 8'h00;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_out      <= |(irq_stat_next & irq_mask_next);
            rd_data_out  <= bus_req_in.rd ? rd_mux : 8'h00;
        end
    end

    // Open-drain pins only pull low, on the selected pair
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            scl_oe_out <= 2'h0;
            sda_oe_out <= 2'h0;
            scl_out    <= 2'h0;
            sda_out    <= 2'h0;
        end
        else
        begin
            scl_oe_out <= pin_sel ? {scl_drive, 1'b0} : {1'b0, scl_drive};
            sda_oe_out <= pin_sel ? {sda_drive, 1'b0} : {1'b0, sda_drive};
            scl_out    <= 2'h0;
            sda_out    <= 2'h0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_buf_read_data: assert property (
        rd_buf |=> rd_data_out == $past(buf_at_cp))
        else $error("buffer read returned wrong byte");
    a_buf_write_store: assert property (
        wr_buf && !(rx_store && bus_ptr_reg == cpu_current_pointer)
        |=> buf_mem[$past(cpu_current_pointer)] == $past(wdata))
        else $error("buffer write not stored at pointer");
    a_ptr_advance_wrap: assert property (
        (wr_buf || rd_buf) |=> cpu_current_pointer
            == PTR_W'($past(cpu_current_pointer) + 1'b1))
        else $error("cpu pointer did not advance");
    a_pin_pair_route: assert property (
        sda_oe_out[~$past(pin_sel)] == 1'b0
        && scl_oe_out[~$past(pin_sel)] == 1'b0)
        else $error("unselected pin pair driven");
    a_stop_irq_post: assert property (
        stop_det && stop_irq_enable |=> irq_stat_reg[isbc_pkg::IRQ_STOP])
        else $error("stop interrupt not posted");
    a_scr_held_off: assert property (
        !cfg_en |=> scr_reg == isbc_pkg::SCR_RESET)
        else $error("status register not held while disabled");
    a_fault_reads_zero: assert property (
        bus_req_in.rd && addr == isbc_pkg::ADDR_SCR
        |=> rd_data_out[isbc_pkg::SCR_FAULT] == 1'b0)
        else $error("bus fault bit read as set");
    a_stop_status_set: assert property (
        stop_det |=> scr_reg[isbc_pkg::SCR_STOP] ##1
        (scr_reg[isbc_pkg::SCR_STOP] || $past(wr_scr)))
        else $error("stop status lost");
    a_ack_auto_clear: assert property (
        bc_set && cfg_en |=> !scr_reg[isbc_pkg::SCR_ACK]
        && scr_reg[isbc_pkg::SCR_BYTE_DONE])
        else $error("ack not cleared on byte complete");
    a_addr_status_set: assert property (
        addr_set |=> scr_reg[isbc_pkg::SCR_ADDRESS])
        else $error("address status not set");
    a_start_clears: assert property (
        start_det |=> !scr_reg[isbc_pkg::SCR_TRANSMIT]
        && !scr_reg[isbc_pkg::SCR_LRB]
        && !scr_reg[isbc_pkg::SCR_BYTE_DONE])
        else $error("start did not clear status bits");

endmodule : isbc_slave_ctrl

// [tb/isbc_master_model.sv]
// ----------------------------------------
// Bus master on the far side of the port
// ----------------------------------------
module isbc_master_model (
    input  wire logic [1:0]            scl_oe_in,
    input  wire logic [1:0]            sda_oe_in,
    input  wire logic                  sel_in,
    output isbc_pkg::isbc_pins_t [1:0] pins_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic scl_drv = 1'b1;
    logic sda_drv = 1'b1;
    wire  scl_w   = scl_drv & ~scl_oe_in[sel_in];
    wire  sda_w   = sda_drv & ~sda_oe_in[sel_in];
    // Open-drain wires; the idle pair rests at its pull-up
    always_comb
    begin
        pins_out = '1;
        pins_out[sel_in] = {scl_w, sda_w};
    end
    // One bit; a stretched clock is waited out, but not forever
    task clk_bit(input logic b, output logic s);
        sda_drv = b;
        #31.25 scl_drv = 1'b1;
        for (int i = 0; i < 4000 && !scl_w; i++) #5;
        #62.5 s = sda_w;
        scl_drv = 1'b0;
        #31.25;
    endtask : clk_bit
    task send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, ack);
    endtask : send_byte
    task start();
        #62.5 sda_drv = 1'b0;
        #62.5 scl_drv = 1'b0;
        #31.25;
    endtask : start
    task stop();
        sda_drv = 1'b0;
        #31.25 scl_drv = 1'b1;
        #62.5 sda_drv = 1'b1;
        #62.5;
    endtask : stop
endmodule : isbc_master_model

// [tb/i2c_slave_buffer_and_control_tb.sv]
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module i2c_slave_buffer_and_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import isbc_pkg::*;
    logic                       clk = 1'b0;
    logic                       reset_n = 1'b0;
    isbc_bus_req_t              req = '0;
    logic [7:0]                 rd_data;
    logic                       irq, ack, rd_pend = 1'b0;
    logic [1:0]                 scl_o, scl_oe, sda_o, sda_oe;
    isbc_pins_t [1:0]           pins;
    logic [15:0]                exp_q[$];
    logic [7:0]                 dat[4];
    int                         n_mismatch = 0;
    int                         n_compared = 0;
    isbc_slave_ctrl i_dut (.core_clk_in(clk), .reset_n_in(reset_n),
        .bus_req_in(req), .rd_data_out(rd_data), .irq_out(irq),
        .pin_pair_in(pins), .scl_out(scl_o), .scl_oe_out(scl_oe),
        .sda_out(sda_o), .sda_oe_out(sda_oe));
    isbc_master_model i_master (.scl_oe_in(scl_oe), .sda_oe_in(sda_oe),
        .sel_in(1'b1), .pins_out(pins));
    initial forever #2.5 clk = ~clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) req <= '0;
    endtask : wr
    // Expected value and care mask are noted before the strobe goes out
    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({e, m});
        @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) req <= '0;
    endtask : rd
    task tally_and_finish();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // Read data stands only in the cycle after the strobe
    always @(posedge clk)
    begin
        rd_pend <= req.rd;
        if (rd_pend)
        begin
            chk(rd_data & exp_q[0][7:0], exp_q[0][15:8]);
            void'(exp_q.pop_front());
        end
        if (reset_n) chk({6'h0, scl_oe[0], sda_oe[0]}, 8'h00);
        if (reset_n) chk({4'h0, scl_o, sda_o}, 8'h00);
    end
    initial
    begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        void'($urandom(32'h8395));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        wr(ADDR_SCR, 8'h14);
        rd(ADDR_SCR, 8'h00, 8'hff);
        rd(8'hf0, 8'h00, 8'hff);
        // Start one below the top so the pointer has to wrap
        wr(ADDR_CPU_BASE, 8'h1e);
        foreach (dat[i])
        begin
            dat[i] = 8'($urandom());
            wr(ADDR_BUF_PORT, dat[i]);
        end
        rd(ADDR_CPU_CUR, 8'h02, 8'h1f);
        wr(ADDR_CPU_BASE, 8'h1e);
        foreach (dat[i]) rd(ADDR_BUF_PORT, dat[i], 8'hff);
        for (int r = 0; r < 4; r++)
        begin
            wr(ADDR_CONFIG, 8'h70 | 8'(r << 2));
            rd(ADDR_CONFIG, 8'h70 | 8'(r << 2), 8'hff);
        end
        // Enable on the second pair with the stop interrupt armed
        wr(ADDR_CONFIG, 8'h71);
        wr(ADDR_IRQ_MASK, 8'h07);
        i_master.start();
        fork
            i_master.send_byte(8'ha0, ack);
            begin
                for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk);
                rd(ADDR_SCR, 8'h09, 8'hff);
                wr(ADDR_SCR, 8'h19);
            end
        join
        chk({7'h0, ack}, 8'h00);
        i_master.stop();
        repeat (10) @(posedge clk);
        rd(ADDR_SCR, 8'h29, 8'hef);
        rd(ADDR_IRQ_STAT, 8'h07, 8'hff);
        wr(ADDR_IRQ_STAT, 8'h07);
        wr(ADDR_SCR, 8'h00);
        rd(ADDR_SCR, 8'h00, 8'hff);
        chk({7'h0, irq}, 8'h00);
        repeat (3) @(posedge clk);
        tally_and_finish();
    end
endmodule : i2c_slave_buffer_and_control_tb
